/* hdl/ifs_defs.svh */
// Constants of the indoor fan speed supervisor
//
// Summary of operation
// - Up zone from bottom: jump to maximum
// - Up zone: add 10 rpm each 10 s
// - Down zone: drop one step each 10 s
// - Fixed zone: hold present target
// - Instant maximum zone: target to maximum
// - Correct duty from speed each half second
// - Clamp offset duty at configured maximum
// - Fault on overspeed, underspeed or lost rhythm
// - On fault stop, retry after 5 s
// - Ignore rhythm loss first 5 s
// - Seven quick faults in row: lockout
// - No restart within 5 s of stop
// - Heating shift with powerful: pipe control +2
// - Heating shift with quiet: pipe control -1
// - Odor sequencer only cooling/dry, auto fan
// - No odor control in standby or antifreeze
// - Compressor on: 1,2,3; off jumps 4
// - Compressor off: 4..7, then 6/7; on jumps 1
// - Thermostat off at start: begin at 4
// - Odor judgement with fan off starts fan
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH

// Clock and time base
`define IFS_CLK_PERIOD_NS 8
`define IFS_TICK_MS 100
`define IFS_TICK_CYCLES (`IFS_TICK_MS * 1000000 / `IFS_CLK_PERIOD_NS)
`define IFS_WINDOW_MS 500
`define IFS_RAMP_MS 10000
`define IFS_RETRY_MS 5000
`define IFS_QUICK_MS 25000
`define IFS_ODOR_STEP_MS 60000
`define IFS_RHYTHM_GAP_MS 1500
`define IFS_WINDOW_TICKS (`IFS_WINDOW_MS / `IFS_TICK_MS)
`define IFS_RAMP_TICKS (`IFS_RAMP_MS / `IFS_TICK_MS)
`define IFS_RETRY_TICKS (`IFS_RETRY_MS / `IFS_TICK_MS)
`define IFS_QUICK_TICKS (`IFS_QUICK_MS / `IFS_TICK_MS)
`define IFS_ODOR_STEP_TICKS (`IFS_ODOR_STEP_MS / `IFS_TICK_MS)
`define IFS_RHYTHM_GAP_TICKS (`IFS_RHYTHM_GAP_MS / `IFS_TICK_MS)

// Speeds in rpm and fault limit
`define IFS_MAX_RPM 12'h05f0
`define IFS_MIN_RPM 12'h04f6
`define IFS_STEP_RPM 12'h000a
`define IFS_OVER_RPM 12'h09f6
`define IFS_UNDER_RPM 12'h0032
`define IFS_RPM_PER_PULSE 12'h0078
`define IFS_FAIL_LIMIT 3'h7

// Odor states
`define IFS_ODOR_NONE 3'h0
`define IFS_ODOR_1 3'h1
`define IFS_ODOR_3 3'h3
`define IFS_ODOR_4 3'h4
`define IFS_ODOR_6 3'h6
`define IFS_ODOR_7 3'h7

// Register offsets
`define IFS_CTRL_OFS 4'h0
`define IFS_SET_RPM_OFS 4'h4
`define IFS_MAX_OFS_OFS 4'h8
`define IFS_STATUS_OFS 4'hc

// Control register fields
`define IFS_C_RUN 0
`define IFS_C_HEAT 1
`define IFS_C_COOL_DRY 2
`define IFS_C_AUTO_FAN 3
`define IFS_C_HOT_START 4
`define IFS_C_DEFROST 5
`define IFS_C_SUPPLY_STOP 6
`define IFS_C_SHIFT 7
`define IFS_C_POWERFUL 8
`define IFS_C_QUIET 9
`define IFS_C_STANDBY 10
`define IFS_C_ANTI_FREEZE 11
`define IFS_C_ZONE_LO 12
`define IFS_C_WIDTH 14

`endif

/* hdl/ifs_indoor_fan_supervisor.sv */
// Fan supervisor: target, duty loop, faults, odor
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "ifs_defs.svh"
module ifs_indoor_fan_supervisor #(
   parameter int TICK_CYCLES = `IFS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Plant indications
   input wire logic compressor_on_i,
   input wire logic thermo_on_i,
   input wire logic fb_pulse_i,
   // Fan motor
   output logic indoor_blower_drive_o,
   output logic pwm_o,
   // Status
   output logic fault_o,
   output logic blower_lockout_o,
   output logic [2:0] odor_state_o
);
   ifs_pkg::ifs_fan_state_e state_reg;
   ifs_pkg::ifs_zone_e zone;
   ifs_pkg::ifs_zone_e zone_prev_reg;
   logic [`IFS_C_WIDTH-1:0] ctrl_reg;
   logic [11:0] set_rpm_reg;
   logic [6:0] max_ofs_reg;
   logic [11:0] target_reg;
   logic [11:0] target_next;
   logic signed [8:0] offset_reg;
   logic [7:0] duty_reg;
   logic [7:0] pwm_cnt_reg;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic tick;
   logic window;
   logic gap;
   logic [11:0] meas_rpm;
   logic [6:0] ramp_cnt_reg;
   logic [5:0] prohibit_reg;
   logic [7:0] run_time_reg;
   logic [2:0] fail_cnt_reg;
   logic power_up_reg;
   logic odor_fan_req_reg;
   logic odor_en_prev_reg;
   logic [9:0] odor_cnt_reg;
   logic comp_on;
   logic thermo_on;
   logic heat_stop;
   logic demand;
   logic start_ok;
   logic grace_over;
   logic fault_now;
   logic ramp_tick;
   logic odor_en;
   logic odor_judge;

   // Saturating add
   function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b,
                                           input logic [11:0] lim);
      logic [12:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[11:0];
   endfunction

   // Saturating subtract
   function automatic logic [11:0] sat_sub(input logic [11:0] a, input logic [11:0] b,
                                           input logic [11:0] lim);
      sat_sub = (a < lim + b) ? lim : a - b;
   endfunction

   // Time base and speed measurement
   ifs_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   ifs_speed_meter u_meter (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .fb_pulse_i(fb_pulse_i),
      .meas_rpm_o(meas_rpm),
      .window_o(window),
      .gap_o(gap)
   );

   // Synchronise compressor and thermostat pins
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else begin
         sync1_reg <= {compressor_on_i, thermo_on_i};
         sync2_reg <= sync1_reg;
      end
   end

   assign comp_on = sync2_reg[1];
   assign thermo_on = sync2_reg[0];
   assign zone = ifs_pkg::ifs_zone_e'(ctrl_reg[`IFS_C_ZONE_LO +: 2]);

   // Register writes
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= 14'h0000;
         set_rpm_reg <= 12'h0000;
         max_ofs_reg <= 7'h00;
      end else if (wr_i) begin
         case (addr_i)
            `IFS_CTRL_OFS: ctrl_reg <= wdata_i[`IFS_C_WIDTH-1:0];
            `IFS_SET_RPM_OFS: set_rpm_reg <= wdata_i[11:0];
            `IFS_MAX_OFS_OFS: max_ofs_reg <= wdata_i[6:0];
            default: ;
         endcase
      end
   end

   // Register reads, data next cycle
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            `IFS_CTRL_OFS: rdata_o <= {18'h0_0000, ctrl_reg};
            `IFS_SET_RPM_OFS: rdata_o <= {20'h0_0000, set_rpm_reg};
            `IFS_MAX_OFS_OFS: rdata_o <= {25'h000_0000, max_ofs_reg};
            `IFS_STATUS_OFS: rdata_o <= {2'h0, indoor_blower_drive_o, odor_state_o,
                                         blower_lockout_o, fault_o, target_reg, meas_rpm};
            default: rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // Ramp timer, restarted on each zone change
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ramp_cnt_reg <= 7'h00;
         zone_prev_reg <= ifs_pkg::IFS_ZONE_FIXED;
      end else begin
         zone_prev_reg <= zone;
         if (zone != zone_prev_reg) ramp_cnt_reg <= 7'h00;
         else if (ramp_tick) ramp_cnt_reg <= 7'h00;
         else if (tick) ramp_cnt_reg <= ramp_cnt_reg + 7'h01;
      end
   end

   assign ramp_tick = tick && ramp_cnt_reg == 7'(`IFS_RAMP_TICKS - 1);
   assign heat_stop = ctrl_reg[`IFS_C_HEAT] & (ctrl_reg[`IFS_C_HOT_START] |
                      ctrl_reg[`IFS_C_DEFROST] | ctrl_reg[`IFS_C_SUPPLY_STOP]);

   // Fan target selection
   always_comb begin
      target_next = target_reg;
      if (!ctrl_reg[`IFS_C_HEAT]) begin
         target_next = set_rpm_reg;
      end else if (heat_stop) begin
         target_next = target_reg;
      end else if (ctrl_reg[`IFS_C_SHIFT]) begin
         if (ctrl_reg[`IFS_C_POWERFUL])
            target_next = sat_add(set_rpm_reg, 12'(2 * `IFS_STEP_RPM), 12'h0fff);
         else if (ctrl_reg[`IFS_C_QUIET])
            target_next = sat_sub(set_rpm_reg, `IFS_STEP_RPM, 12'h0000);
         else
            target_next = set_rpm_reg;
      end else begin
         case (zone)
            ifs_pkg::IFS_ZONE_UP: begin
               if (zone_prev_reg != ifs_pkg::IFS_ZONE_UP) begin
                  if (target_reg <= `IFS_MIN_RPM) target_next = `IFS_MAX_RPM;
               end else if (ramp_tick) begin
                  target_next = sat_add(target_reg, `IFS_STEP_RPM, `IFS_MAX_RPM);
               end
            end
            ifs_pkg::IFS_ZONE_DOWN: begin
               if (ramp_tick)
                  target_next = sat_sub(target_reg, `IFS_STEP_RPM, `IFS_MIN_RPM);
            end
            ifs_pkg::IFS_ZONE_MAX: target_next = `IFS_MAX_RPM;
            default: target_next = target_reg;
         endcase
      end
   end

   // Fan target register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) target_reg <= `IFS_MIN_RPM;
      else target_reg <= target_next;
   end

   // Fan demand and start permission
   assign demand = (ctrl_reg[`IFS_C_RUN] | odor_fan_req_reg) & ~heat_stop;
   assign start_ok = power_up_reg | (prohibit_reg == 6'h00);
   assign grace_over = run_time_reg >= 8'(`IFS_RETRY_TICKS);
   assign fault_now = (window && meas_rpm > `IFS_OVER_RPM) |
                      (grace_over && window && meas_rpm < `IFS_UNDER_RPM) |
                      (grace_over && gap);

   // Fan state machine
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg <= ifs_pkg::IFS_ST_IDLE;
         prohibit_reg <= 6'h00;
         fail_cnt_reg <= 3'h0;
         power_up_reg <= 1'b1;
         fault_o <= 1'b0;
      end else begin
         if (tick && prohibit_reg != 6'h00) prohibit_reg <= prohibit_reg - 6'h01;
         case (state_reg)
            ifs_pkg::IFS_ST_IDLE: begin
               if (demand && start_ok) begin
                  state_reg <= ifs_pkg::IFS_ST_RUN;
                  power_up_reg <= 1'b0;
               end
            end
            ifs_pkg::IFS_ST_RUN: begin
               if (fault_now) begin
                  fault_o <= 1'b1;
                  prohibit_reg <= 6'(`IFS_RETRY_TICKS);
                  if (run_time_reg < 8'(`IFS_QUICK_TICKS)) begin
                     fail_cnt_reg <= fail_cnt_reg + 3'h1;
                     if (fail_cnt_reg + 3'h1 == `IFS_FAIL_LIMIT)
                        state_reg <= ifs_pkg::IFS_ST_LOCK;
                     else
                        state_reg <= ifs_pkg::IFS_ST_WAIT;
                  end else begin
                     fail_cnt_reg <= 3'h1;
                     state_reg <= ifs_pkg::IFS_ST_WAIT;
                  end
               end else if (!demand) begin
                  prohibit_reg <= 6'(`IFS_RETRY_TICKS);
                  state_reg <= ifs_pkg::IFS_ST_IDLE;
               end else if (run_time_reg == 8'(`IFS_QUICK_TICKS)) begin
                  fail_cnt_reg <= 3'h0;
               end
            end
            ifs_pkg::IFS_ST_WAIT: begin
               if (prohibit_reg == 6'h00) begin
                  if (demand) begin
                     state_reg <= ifs_pkg::IFS_ST_RUN;
                     fault_o <= 1'b0;
                  end else begin
                     state_reg <= ifs_pkg::IFS_ST_IDLE;
                  end
               end
            end
            ifs_pkg::IFS_ST_LOCK: state_reg <= ifs_pkg::IFS_ST_LOCK;
            default: state_reg <= ifs_pkg::IFS_ST_IDLE;
         endcase
      end
   end

   // Drive and lockout outputs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         indoor_blower_drive_o <= 1'b0;
         blower_lockout_o <= 1'b0;
      end else begin
         indoor_blower_drive_o <= (state_reg == ifs_pkg::IFS_ST_RUN) && !fault_now && demand;
         blower_lockout_o <= (state_reg == ifs_pkg::IFS_ST_LOCK);
      end
   end

   // Time since fan start in ticks
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) run_time_reg <= 8'h00;
      else if (state_reg != ifs_pkg::IFS_ST_RUN) run_time_reg <= 8'h00;
      else if (tick && run_time_reg != 8'hff) run_time_reg <= run_time_reg + 8'h01;
   end

   // Closed-loop duty offset, once per window
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         offset_reg <= 9'sh000;
      end else if (state_reg != ifs_pkg::IFS_ST_RUN) begin
         offset_reg <= 9'sh000;
      end else if (window) begin
         if (meas_rpm < target_reg && offset_reg < $signed({2'b00, max_ofs_reg}))
            offset_reg <= offset_reg + 9'sh001;
         else if (meas_rpm > target_reg && offset_reg > -$signed({2'b00, max_ofs_reg}))
            offset_reg <= offset_reg - 9'sh001;
      end
   end

   // Duty: target plus offset, saturated
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         duty_reg <= 8'h00;
      end else begin
         if ($signed({3'b000, target_reg[11:4]}) + $signed({{2{offset_reg[8]}}, offset_reg})
             < 11'sh000)
            duty_reg <= 8'h00;
         else if ($signed({3'b000, target_reg[11:4]}) + $signed({{2{offset_reg[8]}}, offset_reg})
                  > 11'sh0ff)
            duty_reg <= 8'hff;
         else
            duty_reg <= 8'(target_reg[11:4] + offset_reg[7:0]);
      end
   end

   // PWM output
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pwm_cnt_reg <= 8'h00;
         pwm_o <= 1'b0;
      end else begin
         pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
         pwm_o <= indoor_blower_drive_o && (pwm_cnt_reg < duty_reg);
      end
   end

   // Odor sequencer enable and step timer
   assign odor_en = ctrl_reg[`IFS_C_RUN] & ctrl_reg[`IFS_C_COOL_DRY] &
                    ctrl_reg[`IFS_C_AUTO_FAN] & ~ctrl_reg[`IFS_C_STANDBY] &
                    ~ctrl_reg[`IFS_C_ANTI_FREEZE];
   assign odor_judge = odor_en && tick && odor_cnt_reg == 10'(`IFS_ODOR_STEP_TICKS - 1);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) odor_cnt_reg <= 10'h000;
      else if (!odor_en || odor_judge) odor_cnt_reg <= 10'h000;
      else if (tick) odor_cnt_reg <= odor_cnt_reg + 10'h001;
   end

   // Odor state progression
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         odor_state_o <= `IFS_ODOR_NONE;
         odor_en_prev_reg <= 1'b0;
      end else begin
         odor_en_prev_reg <= odor_en;
         if (!odor_en) begin
            odor_state_o <= `IFS_ODOR_NONE;
         end else if (!odor_en_prev_reg) begin
            odor_state_o <= thermo_on ? `IFS_ODOR_1 : `IFS_ODOR_4;
         end else if (comp_on && odor_state_o >= `IFS_ODOR_4) begin
            odor_state_o <= `IFS_ODOR_1;
         end else if (!comp_on && odor_state_o < `IFS_ODOR_4) begin
            odor_state_o <= `IFS_ODOR_4;
         end else if (odor_judge) begin
            if (odor_state_o == `IFS_ODOR_7) odor_state_o <= `IFS_ODOR_6;
            else if (odor_state_o != `IFS_ODOR_3) odor_state_o <= odor_state_o + 3'h1;
         end
      end
   end

   // Judgement with fan off starts it
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) odor_fan_req_reg <= 1'b0;
      else if (!odor_en) odor_fan_req_reg <= 1'b0;
      else if (odor_judge && !indoor_blower_drive_o) odor_fan_req_reg <= 1'b1;
   end
endmodule

/* hdl/ifs_pkg.sv */
// Types of the indoor fan speed supervisor
package ifs_pkg;
   typedef enum logic [3:0] {
      IFS_ST_IDLE = 4'b0001,
      IFS_ST_RUN = 4'b0010,
      IFS_ST_WAIT = 4'b0100,
      IFS_ST_LOCK = 4'b1000
   } ifs_fan_state_e;

   typedef enum logic [1:0] {
      IFS_ZONE_FIXED = 2'b00,
      IFS_ZONE_UP = 2'b01,
      IFS_ZONE_DOWN = 2'b10,
      IFS_ZONE_MAX = 2'b11
   } ifs_zone_e;
endpackage

/* hdl/ifs_speed_meter.sv */
// Speed meter: pulses per window and rhythm watch
`timescale 1ns/100ps
`include "ifs_defs.svh"
module ifs_speed_meter (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Time base and feedback pin
   input wire logic tick_i,
   input wire logic fb_pulse_i,
   // Results
   output logic [11:0] meas_rpm_o,
   output logic window_o,
   output logic gap_o
);
   logic [2:0] fb_sync_reg;
   logic [5:0] pulse_cnt_reg;
   logic [3:0] win_cnt_reg;
   logic [4:0] gap_cnt_reg;
   logic edge_seen;

   assign edge_seen = fb_sync_reg[1] & ~fb_sync_reg[2];

   // Two-stage synchroniser then edge stage
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) fb_sync_reg <= 3'h0;
      else fb_sync_reg <= {fb_sync_reg[1:0], fb_pulse_i};
   end

   // Fixed window pulse counting
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pulse_cnt_reg <= 6'h00;
         win_cnt_reg <= 4'h0;
         meas_rpm_o <= 12'h0000;
         window_o <= 1'b0;
      end else begin
         window_o <= 1'b0;
         if (tick_i && win_cnt_reg == 4'(`IFS_WINDOW_TICKS - 1)) begin
            win_cnt_reg <= 4'h0;
            window_o <= 1'b1;
            meas_rpm_o <= 12'({6'h00, pulse_cnt_reg} * `IFS_RPM_PER_PULSE);
            pulse_cnt_reg <= {5'h00, edge_seen};
         end else begin
            if (tick_i) win_cnt_reg <= win_cnt_reg + 4'h1;
            if (edge_seen && pulse_cnt_reg != 6'h22) pulse_cnt_reg <= pulse_cnt_reg + 6'h01;
         end
      end
   end

   // Rhythm watch: too long without an edge
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         gap_cnt_reg <= 5'h00;
         gap_o <= 1'b0;
      end else if (edge_seen) begin
         gap_cnt_reg <= 5'h00;
         gap_o <= 1'b0;
      end else if (tick_i) begin
         if (gap_cnt_reg == 5'(`IFS_RHYTHM_GAP_TICKS)) gap_o <= 1'b1;
         else gap_cnt_reg <= gap_cnt_reg + 5'h01;
      end
   end
endmodule

/* hdl/ifs_tick_gen.sv */
// Time base: one pulse per tick period
`timescale 1ns/100ps
`include "ifs_defs.svh"
module ifs_tick_gen #(
   parameter int TICK_CYCLES = `IFS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Tick
   output logic tick_o
);
   logic [31:0] cnt_reg;

   // Prescaler
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
         cnt_reg <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule

/* tb/ifs_fan_motor_model.sv */
// Fan motor with speed feedback
`timescale 1ns/100ps
module ifs_fan_motor_model (
   // Clock
   input wire logic mclk_i,
   // Drive and mode: 0 stall, 1 steady, 2 race
   input wire logic drive_i,
   input wire logic [1:0] mode_i,
   // Speed feedback
   output logic fb_pulse_o
);
   logic [2:0] phase_reg = 3'h0;
   initial fb_pulse_o = 1'b0;
   // Steady: pulse each 5 clocks; racing: toggle
   always @(posedge mclk_i) begin
      phase_reg <= (phase_reg == 3'h4) ? 3'h0 : phase_reg + 3'h1;
      if (drive_i && mode_i == 2'h2) begin
         fb_pulse_o <= !fb_pulse_o;
      end else if (drive_i && mode_i == 2'h1) begin
         fb_pulse_o <= (phase_reg == 3'h0);
      end
   end
endmodule

/* tb/ifs_sup_checker.sv */
// Port assertions of the fan supervisor
`timescale 1ns/100ps
module ifs_sup_checker #(
   parameter int TICK_CYCLES = 10
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Plant indication
   input wire logic compressor_on_i,
   // Fan and status
   input wire logic indoor_blower_drive_o,
   input wire logic fault_o,
   input wire logic blower_lockout_o,
   input wire logic [2:0] odor_state_o
);
   localparam int HOLD_MIN = 49 * TICK_CYCLES;
   logic [15:0] off_cnt_reg;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Cycles since fan stop
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         off_cnt_reg <= 16'hffff;
      end else if (indoor_blower_drive_o) begin
         off_cnt_reg <= 16'h0000;
      end else if (off_cnt_reg != 16'hffff) begin
         off_cnt_reg <= off_cnt_reg + 16'h0001;
      end
   end
   property p_lock_hold;
      blower_lockout_o |=> blower_lockout_o;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lockout released");
   property p_lock_stop;
      blower_lockout_o |=> !indoor_blower_drive_o;
   endproperty
   a_lock_stop: assert property (p_lock_stop) else $error("fan driven in lockout");
   property p_fault_stop;
      $rose(fault_o) |-> ##[0:1] !indoor_blower_drive_o;
   endproperty
   a_fault_stop: assert property (p_fault_stop) else $error("fan driven on fault");
   property p_restart_clr;
      $rose(indoor_blower_drive_o) |-> ##[0:1] !fault_o;
   endproperty
   a_restart_clr: assert property (p_restart_clr) else $error("fault kept on restart");
   property p_no_early;
      $rose(indoor_blower_drive_o) |-> off_cnt_reg >= HOLD_MIN;
   endproperty
   a_no_early: assert property (p_no_early) else $error("restart too soon");
   property p_odor_step;
      (odor_state_o != 3'h0) && $changed(odor_state_o) && ($past(odor_state_o) != 3'h0)
         |-> (odor_state_o == 3'h4) || (odor_state_o == $past(odor_state_o) + 3'h1)
         || (odor_state_o == 3'h1 && $past(odor_state_o) >= 3'h4)
         || (odor_state_o == 3'h6 && $past(odor_state_o) == 3'h7);
   endproperty
   a_odor_step: assert property (p_odor_step) else $error("odor step illegal");
   property p_comp_off;
      $fell(compressor_on_i) ##1 !compressor_on_i [*5] |-> odor_state_o inside {0, [4:7]};
   endproperty
   a_comp_off: assert property (p_comp_off) else $error("odor not at 4 after stop");
   property p_comp_on;
      $rose(compressor_on_i) ##1 compressor_on_i [*5] |-> odor_state_o <= 3'h3;
   endproperty
   a_comp_on: assert property (p_comp_on) else $error("odor not at 1 after start");
endmodule
bind ifs_indoor_fan_supervisor ifs_sup_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .compressor_on_i(compressor_on_i),
   .indoor_blower_drive_o(indoor_blower_drive_o), .fault_o(fault_o),
   .blower_lockout_o(blower_lockout_o), .odor_state_o(odor_state_o));

/* tb/tb.sv */
// Bench for the fan supervisor
`timescale 1ns/100ps
`include "ifs_defs.svh"
module tb;
   localparam logic [31:0] RUN = 32'h0000_0001;
   localparam logic [31:0] HEAT = 32'h0000_0003;
   localparam logic [31:0] COOL = 32'h0000_000d;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic compressor_on_i = 1'b0;
   logic thermo_on_i = 1'b0;
   logic [1:0] fan_mode = 2'h1;
   logic fb_pulse_i, drive, pwm, fault, lock;
   logic [2:0] odor;
   logic [31:0] rdata_o, v;
   int failures = 0;
   int samples_checked = 0;
   int n;
   always #4 mclk_i = ~mclk_i;
   ifs_indoor_fan_supervisor #(.TICK_CYCLES(10)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .compressor_on_i(compressor_on_i), .thermo_on_i(thermo_on_i), .fb_pulse_i(fb_pulse_i),
      .indoor_blower_drive_o(drive), .pwm_o(pwm), .fault_o(fault), .blower_lockout_o(lock),
      .odor_state_o(odor));
   ifs_fan_motor_model u_motor (.mclk_i(mclk_i), .drive_i(drive), .mode_i(fan_mode),
      .fb_pulse_o(fb_pulse_i));
   // Verdict and comparison
   task automatic finish_test();
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Bounded waits
   task automatic step(input int lim);
      @(posedge mclk_i);
      #1 n++;
      if (n > lim) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic wait_for(input int which, input logic lvl, input int lim);
      n = 0;
      while (((which == 0) ? drive : fault) !== lvl) step(lim);
   endtask
   task automatic odor_next(input logic [2:0] e);
      logic [2:0] cur;
      cur = odor;
      n = 0;
      while (odor === cur) step(6300);
      check({29'h0, odor}, {29'h0, e});
   endtask
   task automatic duty(output logic [31:0] d);
      d = 32'h0;
      repeat (256) begin
         @(posedge mclk_i);
         #1 d = d + {31'h0, pwm};
      end
   endtask
   task automatic ztgt(input logic [31:0] c, input int cyc, input logic [11:0] e);
      wr(`IFS_CTRL_OFS, c);
      repeat (cyc) @(posedge mclk_i);
      rd(`IFS_STATUS_OFS, v);
      check({20'h0, v[23:12]}, {20'h0, e});
   endtask
   // Register reset and decode
   task automatic t_regs();
      rd(`IFS_STATUS_OFS, v);
      check(v, 32'h0000_0000);
      wr(`IFS_MAX_OFS_OFS, 32'h0000_00ff);
      wr(`IFS_STATUS_OFS, 32'hffff_ffff);
      wr(4'h2, 32'hffff_ffff);
      rd(`IFS_MAX_OFS_OFS, v);
      check(v, 32'h0000_007f);
      rd(`IFS_CTRL_OFS, v);
      check(v, 32'h0000_0000);
      rd(4'h2, v);
      check(v, 32'h0000_0000);
      wr(`IFS_MAX_OFS_OFS, 32'h0000_0000);
   endtask
   // Heating stops and target zones
   task automatic t_heat();
      wr(`IFS_CTRL_OFS, RUN);
      wait_for(0, 1'b1, 20);
      for (int i = 0; i < 3; i++) begin
         wr(`IFS_CTRL_OFS, HEAT | (32'h0000_0010 << i));
         wait_for(0, 1'b0, 20);
         check({31'h0, drive}, 32'h0000_0000);
         wr(`IFS_CTRL_OFS, HEAT);
         wait_for(0, 1'b1, 700);
      end
      wr(`IFS_SET_RPM_OFS, 32'h0000_04b0);
      ztgt(HEAT | 32'h0000_0180, 10, 12'h4c4);
      ztgt(HEAT | 32'h0000_0280, 10, 12'h4a6);
      ztgt(HEAT, 1100, 12'h4a6);
      ztgt(HEAT | 32'h0000_1000, 10, 12'h5f0);
      ztgt(HEAT | 32'h0000_1000, 1100, 12'h5f0);
      ztgt(HEAT | 32'h0000_2000, 1050, 12'h5e6);
      ztgt(HEAT | 32'h0000_1000, 1050, 12'h5f0);
      ztgt(HEAT | 32'h0000_2000, 1050, 12'h5e6);
      ztgt(HEAT | 32'h0000_3000, 10, 12'h5f0);
   endtask
   // Overspeed stop and retry
   task automatic t_fault();
      wr(`IFS_CTRL_OFS, RUN);
      wr(`IFS_SET_RPM_OFS, 32'h0000_0640);
      wait_for(0, 1'b1, 700);
      fan_mode <= 2'h2;
      wait_for(1, 1'b1, 300);
      check({31'h0, drive}, 32'h0000_0000);
      fan_mode <= 2'h1;
      wait_for(0, 1'b1, 700);
      check({31'h0, n >= 480}, 32'h0000_0001);
      repeat (2700) @(posedge mclk_i);
   endtask
   // Speed and duty correction
   task automatic t_duty();
      rd(`IFS_STATUS_OFS, v);
      check({20'h0, v[11:0]}, 32'h0000_04b0);
      check({31'h0, fault}, 32'h0000_0000);
      duty(v);
      check(v, 32'h0000_0064);
      wr(`IFS_MAX_OFS_OFS, 32'h0000_0003);
      repeat (450) @(posedge mclk_i);
      duty(v);
      check(v, 32'h0000_0067);
   endtask
   // Stalled rotor until lockout
   task automatic t_lock();
      fan_mode <= 2'h0;
      for (int i = 0; i < 7; i++) begin
         wait_for(0, 1'b1, 700);
         wait_for(1, 1'b1, 800);
         check({31'h0, i == 0 || n >= 480}, 32'h0000_0001);
         repeat (2) @(posedge mclk_i);
         check({31'h0, lock}, {31'h0, i == 6});
      end
      repeat (700) @(posedge mclk_i);
      check({31'h0, drive}, 32'h0000_0000);
   endtask
   // Odor sequencing
   task automatic t_odor();
      wr(`IFS_CTRL_OFS, COOL);
      odor_next(3'h4);
      odor_next(3'h5);
      odor_next(3'h6);
      odor_next(3'h7);
      odor_next(3'h6);
      compressor_on_i <= 1'b1;
      odor_next(3'h1);
      odor_next(3'h2);
      compressor_on_i <= 1'b0;
      odor_next(3'h4);
      wr(`IFS_CTRL_OFS, COOL | 32'h0000_0400);
      odor_next(3'h0);
      thermo_on_i <= 1'b1;
      compressor_on_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      wr(`IFS_CTRL_OFS, COOL);
      odor_next(3'h1);
      wr(`IFS_CTRL_OFS, COOL | 32'h0000_0800);
      odor_next(3'h0);
      wr(`IFS_CTRL_OFS, COOL);
      odor_next(3'h1);
      wr(`IFS_CTRL_OFS, 32'h0000_0005);
      odor_next(3'h0);
   endtask
   // Main sequence, second reset before odor
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_heat();
      t_fault();
      t_duty();
      t_lock();
      rst_n_i <= 1'b0;
      fan_mode <= 2'h1;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_odor();
      finish_test();
   end
endmodule
